/* File: wdbm_pkg.sv */
// wdbm_pkg: register map, field layout, reset values and carriers for the
// watchdog bus monitor counter.
// assumes a 32-bit avalon-mm slave whose byte address is the printed offset.
package wdbm_pkg;
  localparam int ADDR_W = 16;
  localparam logic [15:0] OFF_RELOAD_HIGH = 16'hf4c0;
  localparam logic [15:0] OFF_RELOAD_LOW  = 16'hf4c2;
  localparam logic [15:0] OFF_CNT_HIGH    = 16'hf4c4;
  localparam logic [15:0] OFF_CNT_LOW     = 16'hf4c6;
  localparam logic [15:0] OFF_STATUS      = 16'hf4ca;
  localparam logic [15:0] OFF_MODE_CTRL   = 16'hf4cc;
  localparam logic [15:0] RESET_HALF      = 16'hffff;
  localparam logic [15:0] RESET_RELOAD_HIGH = 16'h0000;
  localparam logic [15:0] RESET_RELOAD_LOW  = 16'hffff;
  localparam logic [7:0]  RESET_STATUS    = 8'h00;
  localparam int STAT_CLKDIS = 0;
  localparam int STAT_BUSMON = 1;
  localparam int STAT_WDTEN  = 7;
  localparam logic [2:0] PULSE_LAST = 3'h7;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

  typedef enum logic [1:0] {WDBM_GP, WDBM_WATCHDOG, WDBM_BUSMON} wdbm_mode_e;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [15:0] address;
    logic [31:0] writedata;
  } wdbm_req_s;
endpackage

/* File: wdbm_pulse.sv */
// wdbm_pulse: stretches a one-cycle timeout into an eight-cycle output.
// assumes trig is a one-cycle pulse in the same clock domain.
`timescale 1ns/1ps
module wdbm_pulse
  import wdbm_pkg::*;
(
  input  wire logic clk,     // clock
  input  wire logic rst_n,   // async reset, active low
  input  wire logic trig,    // timeout event
  output logic      pulse    // stretched level
);
  logic [2:0] cnt;
  logic       busy;
  wire        next_busy = trig | (busy & (cnt != PULSE_LAST));
  wire [2:0]  next_cnt  = trig ? 3'h0 : (busy ? cnt + 3'h1 : 3'h0);

  // 8-state counter; retrigger restarts the window
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy <= 1'b0;
      cnt  <= 3'h0;
    end
    else
    begin
      busy <= next_busy;
      cnt  <= next_cnt;
    end
  end
  assign pulse = busy;
endmodule

/* File: wdbm_top.sv */
// wdbm_top: 32-bit down-counter of the watchdog unit, bus monitor control,
// timeout output and the avalon-mm register window.
// assumes address strobe and cycle done are synchronous, active-low pulses
// from the bus interface unit; lockout decode arrives as a level.
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ps
module wdbm_top
  import wdbm_pkg::*;
#(
  parameter int OUTSTANDING_W = 2
)
(
  input  wire logic        REF_CLK,            // 20 mhz clock
  input  wire logic        RESET_N,            // async reset, active low
  input  wire logic [15:0] AVS_ADDRESS,        // byte address
  input  wire logic        AVS_READ,           // read request
  input  wire logic        AVS_WRITE,          // write request
  input  wire logic [31:0] AVS_WRITEDATA,      // write data
  input  wire logic [3:0]  AVS_BYTEENABLE,     // byte lanes
  output logic      [31:0] AVS_READDATA,       // read data
  output logic             AVS_WAITREQUEST,    // stall
  input  wire logic        ADDRESS_STROBE_N,   // bus cycle start, active low
  input  wire logic        CYCLE_DONE_N,       // bus cycle done, active low
  input  wire logic        CORE_IDLE,          // core idle indication
  input  wire logic        LOCKOUT_DONE,       // lockout decoded: watchdog on
  input  wire logic        LOCKOUT_RELOAD,     // lockout reload pulse
  output logic             TIMEOUT_OUT,        // timeout pin
  output logic             SLAVE_REQUEST_LINE_SEVEN // inverted timeout
);
  import wdbm_pkg::*;

  wdbm_req_s   req;
  logic [31:0] count;
  logic [15:0] reload_value_high;
  logic [15:0] reload_value_low;
  logic        bus_monitor_en;
  logic        clock_disable;
  logic        watchdog_en;
  logic        running;
  logic [OUTSTANDING_W-1:0] outstanding;
  logic        ack;
  logic        timeout_pulse;
  logic        stretched;

  assign req = '{read: AVS_READ, write: AVS_WRITE, address: AVS_ADDRESS,
                 writedata: AVS_WRITEDATA};

  // mode decode
  wire wdbm_mode_e mode = watchdog_en ? WDBM_WATCHDOG :
                          (bus_monitor_en ? WDBM_BUSMON : WDBM_GP);
  wire is_busmon = (mode == WDBM_BUSMON);
  wire is_wd     = (mode == WDBM_WATCHDOG);

  wire strobe = ~ADDRESS_STROBE_N;
  wire done   = ~CYCLE_DONE_N;

  // pipelined pairing: count strobes still awaiting completion
  wire [OUTSTANDING_W-1:0] next_outstanding =
    (strobe & ~done) ? outstanding + 1'b1 :
    (~strobe & done & (outstanding != '0)) ? outstanding - 1'b1 :
    outstanding;
  // counting stops once every strobe has its completion
  wire still_open = (next_outstanding != '0);

  wire idle_hold = is_wd & CORE_IDLE;
  wire enabled   = ~clock_disable & ~idle_hold &
                   (is_busmon ? running : 1'b1);
  wire at_zero   = (count == 32'h0);
  wire [31:0] reload_word = {reload_value_high, reload_value_low};

  wire reload_evt = (is_busmon & strobe)
                  | (is_wd & LOCKOUT_RELOAD)
                  | (enabled & at_zero);

  wire [31:0] next_count = reload_evt ? reload_word :
                           (enabled ? count - 32'h1 : count);
  wire next_running = is_busmon & (strobe | (running & ~(done & ~still_open)));

  // register decode
  wire hit_rh   = (req.address == OFF_RELOAD_HIGH);
  wire hit_rl   = (req.address == OFF_RELOAD_LOW);
  wire hit_ch   = (req.address == OFF_CNT_HIGH);
  wire hit_cl   = (req.address == OFF_CNT_LOW);
  wire hit_st   = (req.address == OFF_STATUS);
  wire [7:0] status_byte = {watchdog_en, 5'h00, bus_monitor_en, clock_disable};
  wire [31:0] rd_mux =
    hit_ch ? {16'h0000, count[31:16]} :
    hit_cl ? {16'h0000, count[15:0]} :
    hit_st ? {24'h000000, status_byte} :
    hit_rh ? {16'h0000, reload_value_high} :
    hit_rl ? {16'h0000, reload_value_low} :
    RD_UNMAPPED;

  // one wait cycle per access, then the answer
  wire access   = req.read | req.write;
  wire wr_take  = req.write & ack;
  wire lo_bytes = |AVS_BYTEENABLE[1:0];
  // lockout freezes reload and status writes until reset
  wire wr_reload_h = wr_take & hit_rh & lo_bytes & ~watchdog_en;
  wire wr_reload_l = wr_take & hit_rl & lo_bytes & ~watchdog_en;
  wire wr_status   = wr_take & hit_st & AVS_BYTEENABLE[0] & ~watchdog_en;
  // counter offsets decode but never write

  wire next_ack = access & ~ack;

  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      count       <= {RESET_HALF, RESET_HALF};
      outstanding <= '0;
      running     <= 1'b0;
    end
    else
    begin
      count       <= next_count;
      outstanding <= is_busmon ? next_outstanding : '0;
      running     <= next_running;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      reload_value_high <= RESET_RELOAD_HIGH;
      reload_value_low  <= RESET_RELOAD_LOW;
    end
    else
    begin
      if (wr_reload_h)
        reload_value_high <= req.writedata[15:0];
      if (wr_reload_l)
        reload_value_low <= req.writedata[15:0];
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      bus_monitor_en <= RESET_STATUS[STAT_BUSMON];
      clock_disable  <= RESET_STATUS[STAT_CLKDIS];
      watchdog_en    <= RESET_STATUS[STAT_WDTEN];
    end
    else if (LOCKOUT_DONE)
    begin
      // lockout forces watchdog mode and clears the writable bits
      watchdog_en    <= 1'b1;
      bus_monitor_en <= 1'b0;
      clock_disable  <= 1'b0;
    end
    else if (wr_status)
    begin
      bus_monitor_en <= req.writedata[STAT_BUSMON];
      clock_disable  <= req.writedata[STAT_CLKDIS];
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      ack          <= 1'b0;
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= 32'h0;
      timeout_pulse <= 1'b0;
    end
    else
    begin
      ack          <= next_ack;
      AVS_WAITREQUEST <= ~next_ack;
      AVS_READDATA <= rd_mux;
      timeout_pulse <= enabled & at_zero;
    end
  end

  // waitrequest is kept as its own flop, always the inverse of ack
  wdbm_pulse u_pulse
  (
    .clk   (REF_CLK),
    .rst_n (RESET_N),
    .trig  (timeout_pulse),
    .pulse (stretched)
  );

  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      TIMEOUT_OUT              <= 1'b0;
      SLAVE_REQUEST_LINE_SEVEN <= 1'b1;
    end
    else
    begin
      TIMEOUT_OUT              <= stretched;
      SLAVE_REQUEST_LINE_SEVEN <= ~stretched;
    end
  end
endmodule

/* File: wdbm_properties.sv */
// wdbm_properties: port-level checks of wdbm_top, bound at the foot.
// assumes one clock domain and the one-wait-state register bus.
`timescale 1ns/1ps
module wdbm_properties
  import wdbm_pkg::*;
(
  input wire logic        REF_CLK,                  // clock
  input wire logic        RESET_N,                  // reset, active low
  input wire logic [15:0] AVS_ADDRESS,              // byte address
  input wire logic        AVS_READ,                 // read request
  input wire logic        AVS_WRITE,                // write request
  input wire logic [31:0] AVS_WRITEDATA,            // write data
  input wire logic [3:0]  AVS_BYTEENABLE,           // byte lanes
  input wire logic [31:0] AVS_READDATA,             // read data
  input wire logic        AVS_WAITREQUEST,          // stall
  input wire logic        ADDRESS_STROBE_N,         // cycle start
  input wire logic        CYCLE_DONE_N,             // cycle done
  input wire logic        CORE_IDLE,                // core idle
  input wire logic        LOCKOUT_DONE,             // watchdog on
  input wire logic        LOCKOUT_RELOAD,           // lockout reload
  input wire logic        TIMEOUT_OUT,              // timeout pin
  input wire logic        SLAVE_REQUEST_LINE_SEVEN  // inverted timeout
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  wire rd_ack = AVS_READ && !AVS_WAITREQUEST;
  wire half = AVS_ADDRESS inside {OFF_RELOAD_HIGH, OFF_RELOAD_LOW, OFF_CNT_HIGH, OFF_CNT_LOW};
  wire mapped = half || AVS_ADDRESS == OFF_STATUS;
  AST_LINE7: assert property (SLAVE_REQUEST_LINE_SEVEN == !TIMEOUT_OUT)
    else $error("line seven not inverse of timeout");
  AST_PULSE_LEN: assert property ($rose(TIMEOUT_OUT) |-> TIMEOUT_OUT[*8])
    else $error("timeout pulse too short");
  AST_PULSE_END: assert property ($fell(TIMEOUT_OUT) |-> $past(TIMEOUT_OUT, 8))
    else $error("timeout pulse ended early");
  AST_ACK_ONE: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("bus answer late");
  AST_ACK_STAND: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("bus answer held too long");
  AST_NO_EARLY: assert property (!AVS_READ && !AVS_WRITE |=> AVS_WAITREQUEST)
    else $error("answer without request");
  AST_UNMAPPED: assert property (rd_ack && !mapped |-> AVS_READDATA == RD_UNMAPPED)
    else $error("unmapped read not zero");
  AST_HALF: assert property (rd_ack && half |-> AVS_READDATA[31:16] == 16'h0000)
    else $error("word read has upper bits");
endmodule

bind wdbm_top wdbm_properties u_props (.REF_CLK, .RESET_N, .AVS_ADDRESS, .AVS_READ,
  .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST,
  .ADDRESS_STROBE_N, .CYCLE_DONE_N, .CORE_IDLE, .LOCKOUT_DONE, .LOCKOUT_RELOAD,
  .TIMEOUT_OUT, .SLAVE_REQUEST_LINE_SEVEN);

/* File: wdbm_biu_model.sv */
// wdbm_biu_model: bus interface unit stand-in, two cycles may be open.
// assumes go is a one-cycle pulse; lag 0 is a cycle that never completes.
`timescale 1ns/1ps
module wdbm_biu_model
(
  input  wire logic       clk,      // clock
  input  wire logic       rst_n,    // reset, active low
  input  wire logic       go,       // open a bus cycle
  input  wire logic [7:0] lag,      // cycles to completion
  output logic            strobe_n, // cycle start, active low
  output logic            done_n    // cycle done, active low
);
  logic [7:0] t0, t1;
  // second slot only while the first is open: pipelined pair
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      t0 <= 8'h00;
      t1 <= 8'h00;
      strobe_n <= 1'b1;
      done_n <= 1'b1;
    end
    else
    begin
      strobe_n <= !go;
      done_n <= !(t0 == 8'h01 || t1 == 8'h01);
      t0 <= (t0 > 8'h01) ? t0 - 8'h01 : (go ? lag : 8'h00);
      t1 <= (t1 > 8'h01) ? t1 - 8'h01 : ((go && t0 > 8'h01) ? lag : 8'h00);
    end
endmodule

/* File: watchdog_bus_monitor_counter_test.sv */
// watchdog_bus_monitor_counter_test: register and bus monitor scenarios.
// assumes wdbm_biu_model opens bus cycles on request.
`timescale 1ns/1ps
module watchdog_bus_monitor_counter_test;
  import wdbm_pkg::*;
  logic        clk, rst_n, rd, wr, wq, idle, lk, go, as_n, cd_n, to, l7;
  logic [15:0] addr, a, b;
  logic [31:0] wd, rdata;
  logic [7:0]  lag;
  int          fail_count, samples_checked;
  wire [2:0]   ev = {!wq, to, !cd_n};
  wdbm_top i_dut (.REF_CLK(clk), .RESET_N(rst_n), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wq), .ADDRESS_STROBE_N(as_n), .CYCLE_DONE_N(cd_n),
    .CORE_IDLE(idle), .LOCKOUT_DONE(lk), .LOCKOUT_RELOAD(1'b0), .TIMEOUT_OUT(to),
    .SLAVE_REQUEST_LINE_SEVEN(l7));
  wdbm_biu_model i_biu (.clk(clk), .rst_n(rst_n), .go(go), .lag(lag), .strobe_n(as_n),
    .done_n(cd_n));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = !clk;
  end
  task close_out;
    if (fail_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wait_ev(input int k, input int lim);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ev[k] !== 1'b1 && n < lim);
    if (ev[k] !== 1'b1)
    begin
      fail_count++;
      close_out;
    end
  endtask
  // edge after release keeps back-to-back calls from double driving
  task bus(input logic w, input logic [15:0] ad, input logic [31:0] d,
           output logic [15:0] q);
    rd <= !w;
    wr <= w;
    addr <= ad;
    wd <= d;
    wait_ev(2, 50);
    q = rdata[15:0];
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task rd2(input logic [15:0] ad);
    bus(1'b0, ad, 32'h0, a);
    bus(1'b0, ad, 32'h0, b);
  endtask
  task cyc(input logic [7:0] l);
    go <= 1'b1;
    lag <= l;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
  endtask
  initial
  begin
    fail_count = 0;
    samples_checked = 0;
    {rst_n, rd, wr, idle, lk, go, lag, addr, wd} = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, OFF_CNT_HIGH, 32'h0, a);
    chk(a, RESET_HALF);
    bus(1'b0, 16'h0000, 32'h0, a);
    chk(a, 16'h0000);
    bus(1'b1, OFF_RELOAD_HIGH, 32'h0, a);
    bus(1'b1, OFF_RELOAD_LOW, 32'h0100, a);
    bus(1'b1, OFF_STATUS, 32'h02, a);
    bus(1'b0, OFF_STATUS, 32'h0, a);
    chk(a & 16'h0083, 16'h0002);
    cyc(8'd8);
    wait_ev(0, 40);
    rd2(OFF_CNT_LOW);
    chk(16'(a == b), 16'h1);
    chk(16'(a < 16'h0100 && a > 16'h00f0), 16'h1);
    bus(1'b1, OFF_CNT_LOW, 32'h1234, b);
    bus(1'b0, OFF_CNT_LOW, 32'h0, b);
    chk(b, a);
    bus(1'b0, OFF_CNT_HIGH, 32'h0, b);
    chk(b, 16'h0000);
    idle <= 1'b1;
    cyc(8'd12);
    cyc(8'd40);
    wait_ev(0, 40);
    rd2(OFF_CNT_LOW);
    chk(16'(a != b), 16'h1);
    wait_ev(0, 60);
    rd2(OFF_CNT_LOW);
    chk(16'(a == b), 16'h1);
    cyc(8'd0);
    wait_ev(1, 400);
    chk(16'(to), 16'h1);
    chk(16'(l7), 16'h0);
    rd2(OFF_CNT_LOW);
    chk(16'(a > 16'h00f0 && a <= 16'h0100), 16'h1);
    lk <= 1'b1;
    // let the lockout settle so both reads see the halted count
    repeat (2) @(posedge clk);
    rd2(OFF_CNT_LOW);
    chk(16'(a == b), 16'h1);
    bus(1'b0, OFF_STATUS, 32'h0, a);
    chk(a & 16'h0083, 16'h0080);
    idle <= 1'b0;
    rd2(OFF_CNT_LOW);
    chk(16'(a != b), 16'h1);
    close_out;
  end
endmodule
